/* core/hlfr_top.sv */
`timescale 1ns/1ps
module hlfr_top #(
    parameter int FAST_CYC = hlfr_pkg::FAST_CONV_CYC,
    parameter int SLOW_CYC = hlfr_pkg::SLOW_CONV_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Strap
    input wire logic i_address_jumper,
    // Field front end, 0.1 mT units
    input wire logic signed [15:0] i_field,
    // Status
    output logic [9:0] o_field_code,
    output logic o_power_down
);
    import hlfr_pkg::*;

    hlfr_state_t state_reg, state_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic ack_reg, ack_next;
    logic oe_next;
    logic wr_en;
    logic rd_fetch;
    logic scl_q_reg, sda_q_reg;
    logic [6:0] own_addr_reg;
    hlfr_ctrl_t ctrl_reg;
    logic [7:0] sens_reg;
    logic [9:0] code_reg;
    logic flag_reg;
    logic [15:0] period_cnt_reg;
    logic conv_start_reg;
    logic conv_done;
    logic [9:0] conv_code;

    // Bus edge and condition detect
    wire logic scl_rise = i_scl & ~scl_q_reg;
    wire logic scl_fall = ~i_scl & scl_q_reg;
    wire logic start_det = scl_q_reg & i_scl & sda_q_reg & ~i_sda;
    wire logic stop_det = scl_q_reg & i_scl & ~sda_q_reg & i_sda;
    wire logic byte_done = scl_fall && bit_cnt_reg == 4'h8;
    wire logic addr_hit = shift_reg[7:1] == own_addr_reg; // RQ13

    // Register read mux
    wire logic [7:0] high_byte = {4'h0, ^code_reg, flag_reg, code_reg[9:8]}; // RQ9
    wire logic [7:0] rd_byte = (ptr_reg == OFS_FIELD_LOW) ? code_reg[7:0] : // RQ8
        (ptr_reg == OFS_FIELD_HIGH) ? high_byte :
        (ptr_reg == OFS_CTRL) ? ctrl_reg :
        (ptr_reg == OFS_SENS) ? sens_reg : 8'h00;
    wire logic flag_clr = rd_fetch && ptr_reg == OFS_FIELD_HIGH;

    // Conversion request
    wire logic [15:0] period_load = ctrl_reg.fast ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1); // RQ5
    wire logic conv_start_next = period_cnt_reg == 16'h0000 && !ctrl_reg.power_down; // RQ6
    hlfr_conv_req_t conv_req;
    assign conv_req = '{field: i_field, sens: sens_reg[1:0], polarity: ctrl_reg.polarity};

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        ack_next = ack_reg;
        oe_next = o_sda_oe;
        wr_en = 1'b0;
        rd_fetch = 1'b0;
        if (stop_det) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else if (start_det) begin
            state_next = ST_ADDR;
            bit_cnt_next = 4'h0;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], i_sda};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        oe_next = 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_next = shift_reg[0];
                            state_next = addr_hit ? ST_ADDR_ACK : ST_IDLE; // RQ13
                            oe_next = addr_hit;
                        end else if (state_reg == ST_PTR) begin
                            ptr_next = shift_reg;
                            state_next = ST_PTR_ACK;
                        end else begin
                            wr_en = 1'b1;
                            state_next = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        oe_next = 1'b0;
                        if (state_reg == ST_WDATA_ACK) begin
                            ptr_next = ptr_reg + 8'h01;
                        end
                        if (state_reg == ST_ADDR_ACK && rw_reg) begin
                            shift_next = rd_byte;
                            oe_next = ~rd_byte[7];
                            rd_fetch = 1'b1;
                            state_next = ST_RDATA;
                        end else begin
                            state_next = (state_reg == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall && bit_cnt_reg == 4'h7) begin
                        oe_next = 1'b0;
                        ptr_next = ptr_reg + 8'h01;
                        state_next = ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_next = ~shift_reg[6];
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        ack_next = ~i_sda;
                    end else if (scl_fall && ack_reg) begin
                        shift_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        bit_cnt_next = 4'h0;
                        rd_fetch = 1'b1;
                        state_next = ST_RDATA;
                    end else if (scl_fall) begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            ack_reg <= 1'b0;
            o_sda_oe <= 1'b0;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            ack_reg <= ack_next;
            o_sda_oe <= oe_next;
            scl_q_reg <= i_scl;
            sda_q_reg <= i_sda;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            own_addr_reg <= i_address_jumper ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW; // RQ13
            ctrl_reg <= CTRL_RESET; // RQ2
            sens_reg <= SENS_RESET; // RQ2
            o_sda_out <= 1'b0;
        end else if (wr_en && ptr_reg == OFS_CTRL) begin
            ctrl_reg <= shift_reg; // RQ4 RQ5 RQ6
        end else if (wr_en && ptr_reg == OFS_SENS) begin
            sens_reg <= shift_reg; // RQ3
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            period_cnt_reg <= 16'h0000;
            conv_start_reg <= 1'b0;
            code_reg <= CODE_MID;
            flag_reg <= 1'b0;
            o_power_down <= 1'b0;
        end else begin
            period_cnt_reg <= (period_cnt_reg == 16'h0000) ? period_load :
                period_cnt_reg - 16'h0001;
            conv_start_reg <= conv_start_next; // RQ6
            o_power_down <= ctrl_reg.power_down; // RQ6
            if (conv_done) begin
                code_reg <= conv_code; // RQ7
            end
            flag_reg <= conv_done | (flag_reg & ~flag_clr);
        end
    end

    assign o_field_code = code_reg;

    hlfr_conv u_conv (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_start(conv_start_reg),
        .i_req(conv_req),
        .o_done(conv_done),
        .o_code(conv_code)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    addr_ack_a: // RQ13
        assert property (state_reg == ST_ADDR && byte_done && !start_det && !stop_det && addr_hit
            |=> state_reg == ST_ADDR_ACK && o_sda_oe)
        else $error("Own address not acknowledged");
    addr_strap_a: // RQ13
        assert property (disable iff (1'b0) i_srst |=> own_addr_reg ==
            ($past(i_address_jumper) ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW))
        else $error("Bus address does not follow strap");
    low_read_a: // RQ8
        assert property (rd_fetch && !start_det && !stop_det && ptr_reg == OFS_FIELD_LOW
            |=> shift_reg == $past(code_reg[7:0]))
        else $error("Low field byte wrong");
    high_read_a: // RQ9
        assert property (rd_fetch && !start_det && !stop_det && ptr_reg == OFS_FIELD_HIGH
            |=> shift_reg[1:0] == $past(code_reg[9:8]) &&
            shift_reg[HIGH_PAR_BIT] == $past(^code_reg))
        else $error("High field byte wrong");
    sens_write_a: // RQ3
        assert property (wr_en && ptr_reg == OFS_SENS |=> sens_reg == $past(shift_reg))
        else $error("Sensitivity write lost");
    ctrl_write_a: // RQ4
        assert property (wr_en && ptr_reg == OFS_CTRL |=> ctrl_reg == $past(shift_reg) ##1
            o_power_down == ctrl_reg.power_down)
        else $error("Control write lost");
    pdn_a: // RQ6
        assert property (ctrl_reg.power_down |=> !conv_start_reg)
        else $error("Conversion started in power-down");
    defaults_a: // RQ2
        assert property ($fell(i_srst) |-> ctrl_reg == CTRL_RESET && sens_reg == SENS_RESET)
        else $error("Defaults not applied after reset");
    flag_set_a: // RQ9
        assert property (conv_done |=> flag_reg)
        else $error("Status flag not set on conversion");

    read_nack_c: cover property (state_reg == ST_RDATA_ACK && scl_fall && !ack_reg);
    sens_wr_c: cover property (wr_en && ptr_reg == OFS_SENS);
    high_rd_c: cover property (rd_fetch && ptr_reg == OFS_FIELD_HIGH);
endmodule

/* core/hlfr_pkg.sv */
// Function
// RQ1: Host waits over 1.5 ms after power-up before any bus transfer; the bench host waits only 200 cycles (1 us).
// RQ2: Without setup writes the sensor runs from its reset defaults.
// RQ3: Sensitivity_select selects the full-scale sensitivity range.
// RQ4: Control operating_control bit 1 selects magnet polarity.
// RQ5: Control operating_control bit 3 selects slow or fast conversion.
// RQ6: Control operating_control bit 0 enters or leaves power-down.
// RQ7: Field code is offset binary: 0 negative, 511 zero, 1023 positive.
// RQ8: Reading offset 00h returns the low eight field code bits.
// RQ9: Offset 01h returns code bits 9:8, status flag and parity above.
// RQ10: Sensitivity codes 0..3 mean 50, 25, 12.5 and 18.7 mT.
// RQ11: Host should pick the smallest range above the magnet peak field.
// RQ12: Code equals field times 511 over sensitivity, plus 511.
// RQ13: Bus address is 56h with strap low, 57h with strap high.
// RQ14: Out-of-range fields clamp the code at 0 or 1023.
package hlfr_pkg;
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PWRUP_WAIT_US = 1500;
    localparam int FAST_CONV_NS = 10000;
    localparam int SLOW_CONV_NS = 40000;
    localparam int FAST_CONV_CYC = (FAST_CONV_NS * 1000) / CLK_PERIOD_PS;
    localparam int SLOW_CONV_CYC = (SLOW_CONV_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [4:0] DIV_STEPS = 5'h18;
    // Bus addresses
    localparam logic [6:0] ADDR_STRAP_LOW = 7'h56;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h57;
    // Register offsets and resets
    localparam logic [7:0] OFS_FIELD_LOW = 8'h00;
    localparam logic [7:0] OFS_FIELD_HIGH = 8'h01;
    localparam logic [7:0] OFS_CTRL = 8'h02;
    localparam logic [7:0] OFS_SENS = 8'h0b;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SENS_RESET = 8'h00;
    localparam int HIGH_FLAG_BIT = 2;
    localparam int HIGH_PAR_BIT = 3;
    // Field code points
    localparam logic [9:0] CODE_MIN = 10'h000;
    localparam logic [9:0] CODE_MID = 10'h1ff;
    localparam logic [9:0] CODE_MAX = 10'h3ff;
    localparam logic [9:0] MAG_SAT = 10'h200;
    localparam logic [23:0] CODE_SCALE = 24'h0001ff;
    // Full scale in 0.1 mT units
    localparam logic [9:0] SENS_50MT = 10'h1f4;
    localparam logic [9:0] SENS_25MT = 10'h0fa;
    localparam logic [9:0] SENS_12P5MT = 10'h07d;
    localparam logic [9:0] SENS_18P7MT = 10'h0bb;

    typedef struct packed {
        logic [3:0] spare_hi;
        logic fast;
        logic spare_lo;
        logic polarity;
        logic power_down;
    } hlfr_ctrl_t;

    typedef struct packed {
        logic signed [15:0] field;
        logic [1:0] sens;
        logic polarity;
    } hlfr_conv_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_PTR = 4'b0011,
        ST_PTR_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } hlfr_state_t;

    function automatic logic [9:0] sens_divisor(input logic [1:0] code);
        case (code)
            2'h0: sens_divisor = SENS_50MT;
            2'h1: sens_divisor = SENS_25MT;
            2'h2: sens_divisor = SENS_12P5MT;
            default: sens_divisor = SENS_18P7MT;
        endcase
    endfunction
endpackage

/* core/hlfr_conv.sv */
`timescale 1ns/1ps
module hlfr_conv (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Request
    input wire logic i_start,
    input hlfr_pkg::hlfr_conv_req_t i_req,
    // Result
    output logic o_done,
    output logic [9:0] o_code
);
    import hlfr_pkg::*;

    logic busy_reg;
    logic neg_reg;
    logic [4:0] step_reg;
    logic [23:0] dvd_reg;
    logic [10:0] rem_reg;
    logic [9:0] div_reg;

    wire logic field_neg = i_req.field[15];
    wire logic [15:0] field_mag = field_neg ? 16'(-i_req.field) : 16'(i_req.field);
    wire logic [23:0] product = 24'(field_mag) * CODE_SCALE; // RQ12
    wire logic [10:0] rem_shift = {rem_reg[9:0], dvd_reg[23]};
    wire logic fits = rem_shift >= {1'b0, div_reg};
    wire logic [9:0] mag = (|dvd_reg[23:9]) ? MAG_SAT : {1'b0, dvd_reg[8:0]}; // RQ14
    wire logic [9:0] neg_code = (mag >= CODE_MID) ? CODE_MIN : CODE_MID - mag; // RQ14
    wire logic [9:0] code_calc = neg_reg ? neg_code : CODE_MID + mag; // RQ7

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            busy_reg <= 1'b0;
            neg_reg <= 1'b0;
            step_reg <= 5'h00;
            dvd_reg <= 24'h000000;
            rem_reg <= 11'h000;
            div_reg <= SENS_50MT;
            o_done <= 1'b0;
            o_code <= CODE_MID;
        end else begin
            o_done <= 1'b0;
            if (!busy_reg && i_start) begin
                busy_reg <= 1'b1;
                step_reg <= 5'h00;
                dvd_reg <= product;
                rem_reg <= 11'h000;
                div_reg <= sens_divisor(i_req.sens); // RQ10
                neg_reg <= field_neg ^ i_req.polarity; // RQ4
            end else if (busy_reg && step_reg == DIV_STEPS) begin
                busy_reg <= 1'b0;
                o_done <= 1'b1;
                o_code <= code_calc;
            end else if (busy_reg) begin
                step_reg <= step_reg + 5'h01;
                rem_reg <= fits ? rem_shift - {1'b0, div_reg} : rem_shift;
                dvd_reg <= {dvd_reg[22:0], fits};
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    conv_latency_a: // RQ12
        assert property (i_start && !busy_reg |-> ##26 o_done)
        else $error("Conversion did not finish on time");
    zero_field_a: // RQ7
        assert property (i_start && !busy_reg && i_req.field == 16'sh0000
            |-> ##26 o_code == CODE_MID)
        else $error("Zero field did not give mid code");
    clamp_a: // RQ14
        assert property (busy_reg && step_reg == DIV_STEPS && (|dvd_reg[23:9])
            |=> o_done && (o_code == CODE_MIN || o_code == CODE_MAX))
        else $error("Over-range field not clamped");
    conv_done_c: cover property (o_done && o_code == CODE_MAX);
endmodule

/* bench/hlfr_host.sv */
`timescale 1ns/1ps
module hlfr_host #(
    parameter int PWRUP_CYC = 200
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Two-wire bus
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    logic scl_reg = 1'b1;
    logic low_reg = 1'b0;
    int up_cnt = 0;
    // Pull-up wire, low while either side pulls
    assign o_sda = ~(low_reg | i_sda_oe);
    assign o_scl = scl_reg;
    always @(posedge i_mclk) begin
        up_cnt <= i_srst ? 0 : up_cnt + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        low_reg <= ~b;
        tick(3);
        scl_reg <= 1'b1;
        tick(2);
        r = o_sda;
        tick(2);
        scl_reg <= 1'b0;
        tick(2);
    endtask
    task automatic start();
        while (up_cnt < PWRUP_CYC) tick(1);
        low_reg <= 1'b0;
        tick(3);
        scl_reg <= 1'b1;
        tick(3);
        low_reg <= 1'b1;
        tick(3);
        scl_reg <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        low_reg <= 1'b1;
        tick(3);
        scl_reg <= 1'b1;
        tick(3);
        low_reg <= 1'b0;
        tick(4);
    endtask
    task automatic send8(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask
    task automatic recv8(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                          output logic ack);
        logic k1, k2, k3;
        start();
        send8({a, 1'b0}, k1);
        send8(o, k2);
        send8(d, k3);
        stop();
        ack = k1 & k2 & k3;
    endtask
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d,
                          output logic ack);
        logic k1, k2, k3;
        start();
        send8({a, 1'b0}, k1);
        send8(o, k2);
        start();
        send8({a, 1'b1}, k3);
        recv8(1'b1, d);
        stop();
        ack = k1 & k2 & k3;
    endtask
    task automatic rd_two(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d0,
                          output logic [7:0] d1, output logic ack);
        logic k1, k2, k3;
        start();
        send8({a, 1'b0}, k1);
        send8(o, k2);
        start();
        send8({a, 1'b1}, k3);
        recv8(1'b0, d0);
        recv8(1'b1, d1);
        stop();
        ack = k1 & k2 & k3;
    endtask
endmodule

/* bench/linear_hall_field_readout_bench.sv */
`timescale 1ns/1ps
module linear_hall_field_readout_bench;
    import hlfr_pkg::*;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_address_jumper = 1'b0;
    logic signed [15:0] i_field = 16'sh0000;
    logic scl, sda, sda_out, sda_oe, pd;
    logic [9:0] code;
    logic [16:0] seed = 17'h1746d;
    logic [7:0] d;
    logic [7:0] d2;
    logic k;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int fs[4];
    int f;
    hlfr_top #(.FAST_CYC(40), .SLOW_CYC(80)) dut (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_address_jumper(i_address_jumper), .i_field(i_field), .o_field_code(code),
        .o_power_down(pd));
    hlfr_host host (.i_mclk(i_mclk), .i_srst(i_srst), .i_sda_oe(sda_oe), .o_scl(scl),
        .o_sda(sda));
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic int exp_code(input int fld, input int sc, input logic pol);
        int v;
        v = (pol ? -fld : fld) * 511 / sc + 511;
        return v < 0 ? 0 : (v > 1023 ? 1023 : v);
    endfunction
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] v);
        host.wr_reg(ADDR_STRAP_LOW, o, v, k);
        chk(k, "write not acked");
    endtask
    task automatic rd_chk(input logic [7:0] o, input logic [7:0] e, input string m);
        host.rd_reg(ADDR_STRAP_LOW, o, d, k);
        chk(k === 1'b1 && d === e, m);
    endtask
    task automatic put(input int fld, input int e, input int tol);
        int dv;
        i_field <= 16'(fld);
        repeat (190) @(posedge i_mclk);
        dv = int'(code) - e;
        chk(!$isunknown(code) && dv <= tol && dv >= -tol, "field code");
    endtask
    task automatic period(input int e);
        logic [9:0] last;
        int nch, t2;
        nch = 0;
        t2 = 0;
        i_field <= -16'sd400;
        @(posedge i_mclk);
        last = code;
        for (int n = 0; n < 300; n++) begin
            @(posedge i_mclk);
            i_field <= i_field + 16'sd1;
            if (code !== last) begin
                nch++;
                if (nch == 2) t2 = n;
                if (nch == 3) chk(n - t2 == e, "conversion period");
                last = code;
            end
        end
        chk(nch >= 3, "too few conversions");
    endtask
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        fs = '{int'(SENS_50MT), int'(SENS_25MT), int'(SENS_12P5MT), int'(SENS_18P7MT)};
        repeat (12) @(posedge i_mclk);
        i_srst <= 1'b0;
        rd_chk(OFS_CTRL, CTRL_RESET, "ctrl reset");
        rd_chk(OFS_SENS, SENS_RESET, "sens reset");
        chk(sda_out === 1'b0, "sda drive level");
        put(0, 511, 0);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_SENS, 8'(s));
            rd_chk(OFS_SENS, 8'(s), "sens readback");
            for (int j = 0; j < 3; j++) begin
                seed = lfsr(seed);
                f = int'(seed % (2 * fs[s] + 1)) - fs[s];
                put(f, exp_code(f, fs[s], 1'b0), 1);
            end
            put(3 * fs[s], 1023, 0);
            put(-3 * fs[s], 0, 0);
            put(-fs[s], 0, 0);
        end
        wr(OFS_SENS, 8'h00);
        wr(OFS_CTRL, 8'h02);
        rd_chk(OFS_CTRL, 8'h02, "ctrl readback");
        put(250, exp_code(250, fs[0], 1'b1), 1);
        put(fs[0], 0, 0);
        wr(OFS_CTRL, 8'h00);
        put(fs[0], 1022, 0);
        wr(OFS_CTRL, 8'h01);
        chk(pd === 1'b1, "power down");
        rd_chk(OFS_FIELD_LOW, 8'hfe, "low byte");
        host.rd_reg(ADDR_STRAP_LOW, OFS_FIELD_HIGH, d, k);
        chk(k === 1'b1 && d === 8'h0f, "high byte");
        rd_chk(OFS_FIELD_HIGH, 8'h0b, "high byte flag clear");
        host.rd_two(ADDR_STRAP_LOW, OFS_FIELD_LOW, d, d2, k);
        chk(k === 1'b1 && d === 8'hfe && d2 === 8'h0b, "paired read");
        put(-fs[0], 1022, 0);
        wr(8'h05, 8'h5a);
        rd_chk(8'h05, 8'h00, "unmapped read");
        wr(OFS_CTRL, 8'h00);
        chk(pd === 1'b0, "power up");
        period(80);
        wr(OFS_CTRL, 8'h08);
        period(40);
        @(posedge i_mclk);
        i_srst <= 1'b1;
        i_address_jumper <= 1'b1;
        repeat (12) @(posedge i_mclk);
        i_srst <= 1'b0;
        host.rd_reg(ADDR_STRAP_HIGH, OFS_CTRL, d, k);
        chk(k === 1'b1 && d === CTRL_RESET, "strap high address");
        host.wr_reg(ADDR_STRAP_LOW, OFS_CTRL, 8'h08, k);
        chk(k === 1'b0, "strap low address refused");
        end_sim();
    end
endmodule
